// ==== hdl/pmcc_clock_ctrl.sv ====
// Power-managed clock control: divider, source select, status register
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pmcc_clock_ctrl
  import pmcc_pkg::*;
#(
  parameter int P_WARMUP_CLOCKS = PMCC_WARMUP_CLOCKS
) (
  input wire logic i_clk_sys, // System clock, 25 MHz
  input wire logic i_rst_b, // Async reset, active low
  input wire logic [7:0] i_addr, // Register address
  input wire logic [7:0] i_wr_data, // Register write data
  input wire logic i_wr_stb, // Write strobe, one cycle
  input wire logic i_rd_stb, // Read strobe, one cycle
  output logic [7:0] o_rd_data, // Read data, cycle after strobe
  input wire logic i_powerfail_level_active, // Power-fail level served
  input wire logic i_high_level_active, // High level in service
  input wire logic i_low_level_active, // Low level in service
  input wire logic i_port0_rx_busy, // Port 0 receiving a word
  input wire logic i_port0_tx_busy, // Port 0 shifting out
  input wire logic i_port1_rx_busy, // Port 1 receiving a word
  input wire logic i_port1_tx_busy, // Port 1 shifting out
  input wire logic i_ext_irq, // Valid enabled external irq pulse
  input wire logic i_ext_irq_high, // That irq has high priority
  input wire logic i_port0_rx_en, // Port 0 receiver enabled
  input wire logic i_port1_rx_en, // Port 1 receiver enabled
  input wire logic i_port0_start_bit, // Port 0 start bit seen, pulse
  input wire logic i_port1_start_bit, // Port 1 start bit seen, pulse
  input wire logic i_port0_tx_write, // Port 0 transmit buffer written
  input wire logic i_port1_tx_write, // Port 1 transmit buffer written
  input wire logic i_xtal_osc_running, // Crystal oscillator started
  input wire logic i_ring_tick, // One ring oscillator clock, pulse
  output logic o_machine_cycle, // Machine cycle strobe for timers
  output logic [1:0] o_divider_code, // Divider code in force
  output logic o_ring_clock_sel, // Core clock taken from ring
  output logic o_crystal_amp_on, // Crystal amplifier enabled
  output logic o_reduced_speed_mode // Running at 64 or 1024 clocks
);

  // Complete register state of the block
  typedef struct packed {
    logic [1:0] divider_sel;
    logic [1:0] divider_act;
    logic auto_return_enable;
    logic crystal_disable;
    logic source_select;
    logic ring_active_flag;
    logic [7:0] rd_data;
  } pmcc_state_t;

  pmcc_state_t st;
  pmcc_state_t next_st;

  logic crystal_ready;
  logic cycle_strobe;
  logic source_tick;
  logic wr_pmr;
  logic wr_extended_flag_register;
  logic rd_hit;
  logic irq_allowed;
  logic switchback_event;
  logic [1:0] wr_div;
  logic wr_src;
  logic wr_xoff;
  logic [7:0] status_word;
  logic [7:0] extended_flag_register_word;
  logic [7:0] pmr_word;

  // Address decode shared by the write and read paths
  function automatic logic pmcc_hit(
    input logic [7:0] addr,
    input logic [7:0] reg_addr
  );
    pmcc_hit = (addr == reg_addr);
  endfunction : pmcc_hit

  // Write strobes per register
  assign wr_pmr = i_wr_stb && pmcc_hit(i_addr, PMCC_ADDR_POWER_MGMT);
  assign wr_extended_flag_register = i_wr_stb && pmcc_hit(i_addr, PMCC_ADDR_EXTENDED_FLAG);
  assign wr_div = {i_wr_data[PMCC_PMR_DIV_HI], i_wr_data[PMCC_PMR_DIV_LO]};
  assign wr_src = i_wr_data[PMCC_EXTENDED_FLAG_REGISTER_SOURCE_SELECT];
  assign wr_xoff = i_wr_data[PMCC_PMR_XTAL_DISABLE];

  // The source clock pulses once per edge on crystal, per tick on ring
  assign source_tick = st.ring_active_flag ? i_ring_tick : 1'b1;

  pmcc_cycle_div u_cycle_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_tick(source_tick),
    .i_ratio(st.divider_act),
    .o_strobe(cycle_strobe)
  );

  // Disabling the amplifier restarts the warm-up from zero
  pmcc_warmup #(
    .CLOCKS(P_WARMUP_CLOCKS)
  ) u_warmup (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_hold(st.crystal_disable),
    .i_osc_running(i_xtal_osc_running),
    .o_ready(crystal_ready)
  );

  // An irq may force a return only if it could really be taken now;
  // a low one is shut out by any level in service, a high one by
  // high or power-fail service
  always_comb begin
    if (i_ext_irq_high) begin
      irq_allowed = !(i_high_level_active || i_powerfail_level_active);
    end else begin
      irq_allowed = !(i_low_level_active || i_high_level_active ||
                      i_powerfail_level_active);
    end
  end

  // Any enabled switchback source
  assign switchback_event =
    (i_ext_irq && irq_allowed) ||
    (i_port0_start_bit && i_port0_rx_en) ||
    (i_port1_start_bit && i_port1_rx_en) ||
    i_port0_tx_write || i_port1_tx_write;

  // Status word is sampled live; software cannot write it
  always_comb begin
    status_word = 8'h00;
    status_word[PMCC_ST_POWERFAIL] = i_powerfail_level_active;
    status_word[PMCC_ST_HIGH] = i_high_level_active;
    status_word[PMCC_ST_LOW] = i_low_level_active;
    status_word[PMCC_ST_XTAL_READY] = crystal_ready;
    status_word[PMCC_ST_PORT1_TX] = i_port1_tx_busy;
    status_word[PMCC_ST_PORT1_RX] = i_port1_rx_busy;
    status_word[PMCC_ST_PORT0_TX] = i_port0_tx_busy;
    status_word[PMCC_ST_PORT0_RX] = i_port0_rx_busy;
  end

  // Extended flag word: only the two clock bits live here
  always_comb begin
    extended_flag_register_word = 8'h00;
    extended_flag_register_word[PMCC_EXTENDED_FLAG_REGISTER_SOURCE_SELECT] = st.source_select;
    extended_flag_register_word[PMCC_EXTENDED_FLAG_REGISTER_RING_ACTIVE] = st.ring_active_flag;
  end

  // Power management word; unimplemented bits read zero
  always_comb begin
    pmr_word = 8'h00;
    pmr_word[PMCC_PMR_DIV_HI] = st.divider_sel[1];
    pmr_word[PMCC_PMR_DIV_LO] = st.divider_sel[0];
    pmr_word[PMCC_PMR_AUTO_RETURN] = st.auto_return_enable;
    pmr_word[PMCC_PMR_XTAL_DISABLE] = st.crystal_disable;
  end

  assign rd_hit = i_rd_stb;

  // Next-state logic for all software and hardware controls
  always_comb begin
    next_st = st;

    // Divider field: reduced rates only from divide-by-4,
    // reserved code ignored, return to 4 always allowed
    if (wr_pmr) begin
      case (pmcc_div_t'(wr_div))
        PMCC_DIV_4: begin
          next_st.divider_sel = PMCC_DIV_4;
        end
        PMCC_DIV_64, PMCC_DIV_1024: begin
          if (st.divider_sel == PMCC_DIV_4) begin
            next_st.divider_sel = wr_div;
          end
        end
        default: begin
          next_st.divider_sel = st.divider_sel;
        end
      endcase
      next_st.auto_return_enable =
        i_wr_data[PMCC_PMR_AUTO_RETURN];
      // Amplifier off only while the ring is selected
      if (!wr_xoff) begin
        next_st.crystal_disable = 1'b0;
      end else if (!st.source_select) begin
        next_st.crystal_disable = 1'b1;
      end
    end

    // Hardware return wins over a same-cycle software write; the
    // source bits are deliberately left alone
    if (st.auto_return_enable && switchback_event) begin
      next_st.divider_sel = PMCC_DIV_4;
    end

    // Source select: crystal only once it is stable and powered
    if (wr_extended_flag_register) begin
      if (!wr_src) begin
        next_st.source_select = 1'b0;
      end else if (crystal_ready && !st.crystal_disable) begin
        next_st.source_select = 1'b1;
      end
    end

    // Divider and source move at a machine-cycle boundary, so a
    // selection lands at the first cycle strobe after it is made; the
    // two are handled apart so neither waits on the other
    if (cycle_strobe) begin
      next_st.divider_act = st.divider_sel;
      if (!st.source_select) begin
        next_st.ring_active_flag = 1'b1;
      end else if (!st.crystal_disable && i_xtal_osc_running) begin
        next_st.ring_active_flag = 1'b0;
      end
    end

    // Read data stand for exactly one cycle after the strobe
    next_st.rd_data = PMCC_RD_IDLE;
    if (rd_hit) begin
      if (pmcc_hit(i_addr, PMCC_ADDR_STATUS)) begin
        next_st.rd_data = status_word;
      end else if (pmcc_hit(i_addr, PMCC_ADDR_EXTENDED_FLAG)) begin
        next_st.rd_data = extended_flag_register_word;
      end else if (pmcc_hit(i_addr, PMCC_ADDR_POWER_MGMT)) begin
        next_st.rd_data = pmr_word;
      end else begin
        next_st.rd_data = PMCC_RD_IDLE;
      end
    end
  end

  // Power-on: divide by 4, crystal source, amplifier on, no return
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st.divider_sel <= PMCC_DIV_4;
      st.divider_act <= PMCC_DIV_4;
      st.auto_return_enable <= PMCC_RST_AUTO_RETURN;
      st.crystal_disable <= PMCC_RST_XTAL_DISABLE;
      st.source_select <= PMCC_RST_SOURCE_SELECT;
      st.ring_active_flag <= 1'b0;
      st.rd_data <= PMCC_RD_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; the cycle strobe paces core and timers alike
  assign o_rd_data = st.rd_data;
  assign o_machine_cycle = cycle_strobe;
  assign o_divider_code = st.divider_act;
  assign o_ring_clock_sel = st.ring_active_flag;
  assign o_crystal_amp_on = !st.crystal_disable;
  assign o_reduced_speed_mode = (st.divider_act != PMCC_DIV_4);

endmodule : pmcc_clock_ctrl
`default_nettype wire

// ==== hdl/pmcc_cycle_div.sv ====
// Machine-cycle divider: one strobe per 4, 64 or 1024 source clocks
`timescale 1ns/1ps
`default_nettype none
module pmcc_cycle_div
  import pmcc_pkg::*;
(
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_tick, // One source clock has passed
  input wire logic [1:0] i_ratio, // Divider code in force
  output logic o_strobe // Machine cycle boundary pulse
);

  typedef struct packed {
    logic [PMCC_CYC_W-1:0] count;
    logic strobe;
  } pmcc_div_state_t;

  pmcc_div_state_t st;
  pmcc_div_state_t next_st;

  // Count source clocks; wrap to zero so a new ratio starts clean
  always_comb begin
    next_st = st;
    next_st.strobe = 1'b0;
    if (i_tick) begin
      if (st.count >= pmcc_cycle_last(pmcc_div_t'(i_ratio))) begin
        next_st.count = '0;
        next_st.strobe = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_strobe = st.strobe;

endmodule : pmcc_cycle_div
`default_nettype wire

// ==== hdl/pmcc_pkg.sv ====
// Package with register map, field layout and timing of the clock control
package pmcc_pkg;

  // Register addresses on the 8-bit special function space
  localparam logic [7:0] PMCC_ADDR_EXTENDED_FLAG = 8'h91;
  localparam logic [7:0] PMCC_ADDR_POWER_MGMT = 8'hC4;
  localparam logic [7:0] PMCC_ADDR_STATUS = 8'hC5;

  // Power management register fields
  localparam int PMCC_PMR_DIV_HI = 7;
  localparam int PMCC_PMR_DIV_LO = 6;
  localparam int PMCC_PMR_AUTO_RETURN = 5;
  localparam int PMCC_PMR_XTAL_DISABLE = 3;

  // Extended flag register fields
  localparam int PMCC_EXTENDED_FLAG_REGISTER_SOURCE_SELECT = 3;
  localparam int PMCC_EXTENDED_FLAG_REGISTER_RING_ACTIVE = 2;

  // Status register fields
  localparam int PMCC_ST_POWERFAIL = 7;
  localparam int PMCC_ST_HIGH = 6;
  localparam int PMCC_ST_LOW = 5;
  localparam int PMCC_ST_XTAL_READY = 4;
  localparam int PMCC_ST_PORT1_TX = 3;
  localparam int PMCC_ST_PORT1_RX = 2;
  localparam int PMCC_ST_PORT0_TX = 1;
  localparam int PMCC_ST_PORT0_RX = 0;

  // Divider field encodings
  typedef enum logic [1:0] {
    PMCC_DIV_RESERVED = 2'b00,
    PMCC_DIV_4 = 2'b01,
    PMCC_DIV_64 = 2'b10,
    PMCC_DIV_1024 = 2'b11
  } pmcc_div_t;

  // Reset values
  localparam logic PMCC_RST_SOURCE_SELECT = 1'b1;
  localparam logic PMCC_RST_XTAL_DISABLE = 1'b0;
  localparam logic PMCC_RST_AUTO_RETURN = 1'b0;
  localparam logic PMCC_RST_XTAL_READY = 1'b1;
  localparam logic [7:0] PMCC_RD_IDLE = 8'h00;

  // Crystal warm-up length in crystal clocks
  localparam int PMCC_WARMUP_CLOCKS = 65536;

  // Last count of each machine cycle, width of the cycle counter
  localparam int PMCC_CYC_W = 10;
  localparam logic [PMCC_CYC_W-1:0] PMCC_LAST_4 = 10'h003;
  localparam logic [PMCC_CYC_W-1:0] PMCC_LAST_64 = 10'h03F;
  localparam logic [PMCC_CYC_W-1:0] PMCC_LAST_1024 = 10'h3FF;

  // Last count of a machine cycle for a divider code
  function automatic logic [PMCC_CYC_W-1:0] pmcc_cycle_last(
    input pmcc_div_t code
  );
    case (code)
      PMCC_DIV_64: pmcc_cycle_last = PMCC_LAST_64;
      PMCC_DIV_1024: pmcc_cycle_last = PMCC_LAST_1024;
      default: pmcc_cycle_last = PMCC_LAST_4;
    endcase
  endfunction : pmcc_cycle_last

endpackage : pmcc_pkg

// ==== hdl/pmcc_warmup.sv ====
// Crystal warm-up timer that raises the ready flag after a clock count
`timescale 1ns/1ps
`default_nettype none
module pmcc_warmup #(
  parameter int CLOCKS = 65536
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst_b, // Async reset, active low
  input wire logic i_hold, // Crystal amplifier switched off
  input wire logic i_osc_running, // Oscillator has started
  output logic o_ready // Crystal stable
);

  localparam int CW = (CLOCKS > 1) ? $clog2(CLOCKS) : 1;
  localparam logic [CW-1:0] LAST = CW'(CLOCKS - 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic ready;
  } pmcc_wu_state_t;

  pmcc_wu_state_t st;
  pmcc_wu_state_t next_st;

  // Hold clears the count; counting only after the oscillator runs
  always_comb begin
    next_st = st;
    if (i_hold) begin
      next_st.count = '0;
      next_st.ready = 1'b0;
    end else if (!st.ready && i_osc_running) begin
      if (st.count == LAST) begin
        next_st.ready = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  // Ready comes out of reset set: the power-on interval already waited
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st.count <= '0;
      st.ready <= pmcc_pkg::PMCC_RST_XTAL_READY;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready = st.ready;

endmodule : pmcc_warmup
`default_nettype wire

// ==== tb/pmcc_clock_ctrl_checker.sv ====
// Port-level assertions for the clock control
`timescale 1ns/1ps
`default_nettype none
module pmcc_clock_ctrl_checker
  import pmcc_pkg::*;
#(
  parameter int P_WARMUP_CLOCKS = 65536
) (
  input wire logic i_clk_sys, // Clock
  input wire logic i_rst_b, // Reset
  input wire logic [7:0] i_addr, // Address
  input wire logic i_rd_stb, // Read strobe
  input wire logic [7:0] o_rd_data, // Read data
  input wire logic i_powerfail_level_active, // Level
  input wire logic i_high_level_active, // Level
  input wire logic i_low_level_active, // Level
  input wire logic i_port0_rx_busy, // Activity
  input wire logic i_port0_tx_busy, // Activity
  input wire logic i_port1_rx_busy, // Activity
  input wire logic i_port1_tx_busy, // Activity
  input wire logic o_machine_cycle, // Cycle strobe
  input wire logic [1:0] o_divider_code, // Divider
  input wire logic o_ring_clock_sel, // Ring
  input wire logic o_crystal_amp_on, // Amplifier
  input wire logic o_reduced_speed_mode // Reduced
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  // Status reads reflect inputs of the strobe cycle
  property p_rd_levels;
    $past(i_rd_stb) && $past(i_addr) == PMCC_ADDR_STATUS |->
      o_rd_data[7:5] == {$past(i_powerfail_level_active),
      $past(i_high_level_active), $past(i_low_level_active)};
  endproperty
  a_rd_levels: assert property (p_rd_levels) else $error("levels");
  property p_rd_ports;
    $past(i_rd_stb) && $past(i_addr) == PMCC_ADDR_STATUS |->
      o_rd_data[3:0] == {$past(i_port1_tx_busy), $past(i_port1_rx_busy),
      $past(i_port0_tx_busy), $past(i_port0_rx_busy)};
  endproperty
  a_rd_ports: assert property (p_rd_ports) else $error("ports");
  // Read data stands only after a strobe
  property p_rd_idle;
    !$past(i_rd_stb) |-> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rd idle");
  property p_reduced;
    o_reduced_speed_mode == (o_divider_code != 2'h1) && o_divider_code != 2'h0;
  endproperty
  a_reduced: assert property (p_reduced) else $error("reduced");
  // Settings move only at a machine cycle boundary
  property p_div_edge;
    $changed(o_divider_code) |-> $past(o_machine_cycle);
  endproperty
  a_div_edge: assert property (p_div_edge) else $error("div edge");
  property p_src_edge;
    $changed(o_ring_clock_sel) |-> $past(o_machine_cycle);
  endproperty
  a_src_edge: assert property (p_src_edge) else $error("src edge");
  property p_xtal_need;
    $fell(o_ring_clock_sel) |-> $past(o_crystal_amp_on);
  endproperty
  a_xtal_need: assert property (p_xtal_need) else $error("xtal off");
  // Steady divide-by-4 on crystal gives a strobe every fourth edge
  property p_cycle4;
    o_machine_cycle && o_divider_code == 2'h1 && !o_ring_clock_sel ##1
      o_divider_code == 2'h1 && !o_ring_clock_sel |->
      (!o_machine_cycle)[*3] ##1 o_machine_cycle;
  endproperty
  a_cycle4: assert property (p_cycle4) else $error("cycle 4");
  c_div64: cover property (o_divider_code == 2'h2);
  c_div1024: cover property (o_divider_code == 2'h3);
  c_ring: cover property ($rose(o_ring_clock_sel));
  c_back: cover property ($fell(o_reduced_speed_mode));
endmodule : pmcc_clock_ctrl_checker

bind pmcc_clock_ctrl pmcc_clock_ctrl_checker #(
  .P_WARMUP_CLOCKS(P_WARMUP_CLOCKS)) u_chk (.i_clk_sys(i_clk_sys),
  .i_rst_b(i_rst_b), .i_addr(i_addr), .i_rd_stb(i_rd_stb),
  .o_rd_data(o_rd_data), .i_powerfail_level_active(i_powerfail_level_active),
  .i_high_level_active(i_high_level_active),
  .i_low_level_active(i_low_level_active), .i_port0_rx_busy(i_port0_rx_busy),
  .i_port0_tx_busy(i_port0_tx_busy), .i_port1_rx_busy(i_port1_rx_busy),
  .i_port1_tx_busy(i_port1_tx_busy), .o_machine_cycle(o_machine_cycle),
  .o_divider_code(o_divider_code), .o_ring_clock_sel(o_ring_clock_sel),
  .o_crystal_amp_on(o_crystal_amp_on),
  .o_reduced_speed_mode(o_reduced_speed_mode));
`default_nettype wire

// ==== tb/tb_power_managed_clock_control.sv ====
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_power_managed_clock_control
  import pmcc_pkg::*;
;
  localparam logic [7:0] EXF = PMCC_ADDR_EXTENDED_FLAG;
  localparam logic [7:0] REDUCED_SPEED_MODE = PMCC_ADDR_POWER_MGMT;
  localparam logic [7:0] STA = PMCC_ADDR_STATUS;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wr_data = 8'h00;
  logic i_wr_stb = 1'b0;
  logic i_rd_stb = 1'b0;
  logic [6:0] st_in = 7'h00; // pf, high, low, p1 tx, p1 rx, p0 tx, p0 rx
  logic [7:0] ev = 8'h0C; // irq, irq high, rx en 0/1, start 0/1, tx wr 0/1
  logic osc_run = 1'b1;
  logic ring_tick = 1'b0;
  logic [7:0] o_rd_data;
  logic [1:0] o_divider_code;
  logic o_machine_cycle;
  logic o_ring_clock_sel;
  logic o_crystal_amp_on;
  logic o_reduced_speed_mode;
  logic [31:0] seed = 32'h0000180A;
  int fails = 0;
  int checked = 0;
  int n;

  pmcc_clock_ctrl #(.P_WARMUP_CLOCKS(8)) dut (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
    .i_powerfail_level_active(st_in[6]), .i_high_level_active(st_in[5]),
    .i_low_level_active(st_in[4]), .i_port1_tx_busy(st_in[3]),
    .i_port1_rx_busy(st_in[2]), .i_port0_tx_busy(st_in[1]),
    .i_port0_rx_busy(st_in[0]), .i_ext_irq(ev[0]), .i_ext_irq_high(ev[1]),
    .i_port0_rx_en(ev[2]), .i_port1_rx_en(ev[3]),
    .i_port0_start_bit(ev[4]), .i_port1_start_bit(ev[5]),
    .i_port0_tx_write(ev[6]), .i_port1_tx_write(ev[7]),
    .i_xtal_osc_running(osc_run), .i_ring_tick(ring_tick),
    .o_machine_cycle(o_machine_cycle), .o_divider_code(o_divider_code),
    .o_ring_clock_sel(o_ring_clock_sel), .o_crystal_amp_on(o_crystal_amp_on),
    .o_reduced_speed_mode(o_reduced_speed_mode));

  // 40 ns clock; ring ticks every other edge so ring cycles run slower
  always #20 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) ring_tick <= ~ring_tick;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    xs = t ^ (t << 5);
  endfunction : xs
  // Status byte predicted from the level and activity inputs
  function automatic logic [7:0] exp_st(input logic [6:0] s);
    exp_st = {s[6:4], 1'b1, s[3:0]};
  endfunction : exp_st

  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_wr_stb <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_clk_sys);
    i_wr_stb <= 1'b0;
  endtask : wr
  // Read data is taken one ns after the edge that closes the strobe cycle
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [7:0] e);
    @(posedge i_clk_sys);
    i_rd_stb <= 1'b1;
    i_addr <= a;
    @(posedge i_clk_sys);
    i_rd_stb <= 1'b0;
    #1;
    chk(nm, {8'h00, o_rd_data}, {8'h00, e});
  endtask : rchk
  task automatic pulse(input int k);
    @(posedge i_clk_sys);
    ev[k] <= 1'b1;
    @(posedge i_clk_sys);
    ev[k] <= 1'b0;
  endtask : pulse
  // Waits for {ring select, divider code}; a spent bound ends the run
  task automatic wait_for(input logic [2:0] want, input int lim);
    int k;
    k = 0;
    // Step off the edge so registered outputs are settled
    #1;
    while ({o_ring_clock_sel, o_divider_code} !== want && k < lim) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    chk("clock state", {13'h0000, o_ring_clock_sel, o_divider_code},
        {13'h0000, want});
    if (k >= lim) finish_test();
  endtask : wait_for
  // Edges from one machine cycle strobe to the next
  task automatic period(output int p);
    int k;
    k = 0;
    p = 0;
    while (o_machine_cycle !== 1'b1 && k < 2100) begin
      @(posedge i_clk_sys);
      #1;
      k++;
    end
    do begin
      @(posedge i_clk_sys);
      #1;
      p++;
    end while (o_machine_cycle !== 1'b1 && p < 2100);
    if (k >= 2100 || p >= 2100) begin
      fails++;
      finish_test();
    end
  endtask : period
  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (8) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    // Reset values, unmapped read, refused crystal disable
    rchk("extended_flag_register", EXF, 8'h08);
    rchk("pmr", REDUCED_SPEED_MODE, 8'h40);
    rchk("status", STA, 8'h10);
    rchk("unmapped", 8'h92, 8'h00);
    wr(REDUCED_SPEED_MODE, 8'h48);
    rchk("pmr xoff", REDUCED_SPEED_MODE, 8'h40);
    chk("amp", {15'h0000, o_crystal_amp_on}, 16'h0001);
    $display("reset test done");
    // Random levels and activity seen in status; writes ignored
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      @(posedge i_clk_sys);
      st_in <= seed[6:0];
      rchk("status", STA, exp_st(seed[6:0]));
    end
    wr(STA, 8'hEF);
    rchk("status ro", STA, exp_st(seed[6:0]));
    st_in <= 7'h00;
    $display("status test done");
    // Divider codes, blocked direct step, reserved code
    wr(REDUCED_SPEED_MODE, 8'h80);
    wait_for(3'b010, 8);
    wr(REDUCED_SPEED_MODE, 8'hC0);
    rchk("pmr 64 to 1024", REDUCED_SPEED_MODE, 8'h80);
    period(n);
    chk("cycle 64", n[15:0], 16'h0040);
    wr(REDUCED_SPEED_MODE, 8'h40);
    wait_for(3'b001, 80);
    wr(REDUCED_SPEED_MODE, 8'hC0);
    rchk("pmr 1024", REDUCED_SPEED_MODE, 8'hC0);
    wait_for(3'b011, 80);
    period(n);
    chk("cycle 1024", n[15:0], 16'h0400);
    wr(REDUCED_SPEED_MODE, 8'h00);
    rchk("reserved", REDUCED_SPEED_MODE, 8'hC0);
    wr(REDUCED_SPEED_MODE, 8'h40);
    wait_for(3'b001, 1100);
    $display("divider test done");
    // Each switchback source, then blocked cases
    for (int k = 0; k < 5; k++) begin
      wr(REDUCED_SPEED_MODE, 8'hA0);
      pulse(k == 0 ? 0 : k + 3);
      rchk("switchback", REDUCED_SPEED_MODE, 8'h60);
    end
    wr(REDUCED_SPEED_MODE, 8'hA0);
    st_in <= 7'h10;
    pulse(0);
    rchk("low irq blocked", REDUCED_SPEED_MODE, 8'hA0);
    ev[1] <= 1'b1;
    pulse(0);
    rchk("high irq", REDUCED_SPEED_MODE, 8'h60);
    ev[2:1] <= 2'b00;
    st_in <= 7'h00;
    wr(REDUCED_SPEED_MODE, 8'hA0);
    pulse(4);
    rchk("rx off", REDUCED_SPEED_MODE, 8'hA0);
    wr(REDUCED_SPEED_MODE, 8'h80);
    pulse(6);
    rchk("no return", REDUCED_SPEED_MODE, 8'h80);
    wr(REDUCED_SPEED_MODE, 8'h40);
    ev[2] <= 1'b1;
    $display("switchback test done");
    // Ring, crystal off, warm-up and return to crystal
    wr(EXF, 8'h00);
    wait_for(3'b101, 1100);
    rchk("extended_flag_register ring", EXF, 8'h04);
    wr(REDUCED_SPEED_MODE, 8'h08);
    rchk("not ready", STA, 8'h00);
    chk("amp", {15'h0000, o_crystal_amp_on}, 16'h0000);
    wr(EXF, 8'h08);
    rchk("extended_flag_register refused", EXF, 8'h04);
    wr(REDUCED_SPEED_MODE, 8'hA8);
    pulse(7);
    rchk("ring back", REDUCED_SPEED_MODE, 8'h68);
    // Remote dummy character: its start bit alone restores divide-by-4
    wr(REDUCED_SPEED_MODE, 8'hA8);
    pulse(4);
    rchk("dummy wakes", REDUCED_SPEED_MODE, 8'h68);
    wait_for(3'b101, 1100);
    osc_run <= 1'b0;
    wr(REDUCED_SPEED_MODE, 8'h60);
    repeat (12) @(posedge i_clk_sys);
    rchk("no osc", STA, 8'h00);
    osc_run <= 1'b1;
    // Ready lands on the eighth counted edge
    repeat (5) @(posedge i_clk_sys);
    rchk("warming", STA, 8'h00);
    rchk("ready", STA, 8'h10);
    wr(EXF, 8'h08);
    wait_for(3'b001, 40);
    rchk("extended_flag_register xtal", EXF, 8'h08);
    $display("source test done");
    finish_test();
  end
endmodule : tb_power_managed_clock_control
`default_nettype wire
